// File: rtl/hcsp_top.sv
// device-side reset, boot, load select and mode-0 serial slave
`timescale 1ns/1ns
`include "hcsp_defines.svh"
// How it works
// RULE_01: while hard reset is low the device is held in reset and after release it boots.
// RULE_02: the host holds hard reset low at least 1us after supplies settle.
// RULE_03: with tied or mis-ordered supplies the host holds reset low at least 1ms.
// RULE_04: when boot completes the device starts linearizing with no host action.
// RULE_05: load select low is normal mode, high routes the serial bus to the eeprom.
// RULE_06: the host keeps load select high through programming and lowers it after.
// RULE_07: after programming the host pulses hard reset low for at least 1us.
// RULE_08: the serial port is mode 0, sampling on rising and shifting on falling edges.
// RULE_09: the master clocks only in transactions between 50 kHz and 10 MHz near 50% duty.
// RULE_10: the device joins a transfer only while the select is low.
// RULE_11: the data output is high impedance outside a transaction.
// RULE_12: bits received are a command byte followed by a data byte.
// RULE_13: shared buses give each slave its own select.
// RULE_14: the reference clock is stable through boot.
// RULE_15: a non 20 MHz reference is first selected by programming the eeprom.
// RULE_16: the reference select accepts seven frequency codes from 10 to 30.72 MHz.
// RULE_17: clock edges with select high are ignored and a partial frame is dropped.
module hcsp_top import hcsp_pkg::*; #(
	parameter int BOOT_CYCLES = `HCSP_BOOT_CYCLES
) (
	// system
	input wire logic clk,
	input wire logic rst_b,
	// control pins
	input wire logic hard_reset_low,
	input wire logic eeprom_load_sel,
	// serial link
	input wire logic serial_clock_in,
	input wire logic port_select_n,
	input wire logic serial_in,
	output logic serial_out,
	output logic serial_out_oe,
	// status to the core
	output logic core_reset_q,
	output logic booted_q,
	output logic linearize_q,
	output logic [2:0] ref_sel_q,
	// received words
	output logic word_valid_q,
	output hcsp_word_t word_q,
	input wire logic word_ready
);
	// ==========================================================
	// link domain: shift register on the serial clock
	logic [15:0] sh_q, sh_d;
	logic [4:0] cnt_q, cnt_d;
	logic tog_q, tog_d;
	logic [15:0] cap_q, cap_d;
	logic [7:0] tx_q, tx_d;
	logic oe_q, oe_d;
	logic [7:0] stat_l;
	always_comb begin
		sh_d = {sh_q[14:0], serial_in}; // RULE_08 RULE_12
		cnt_d = cnt_q + 5'h01;
		tog_d = tog_q;
		cap_d = cap_q;
		if (cnt_q == 5'h0F) begin
			tog_d = ~tog_q;
			cap_d = {sh_q[14:0], serial_in};
			cnt_d = 5'h00;
		end
	end
	// select high clears the frame asynchronously to the link clock
	always_ff @(posedge serial_clock_in or posedge port_select_n) begin
		if (port_select_n) begin // RULE_10 RULE_17
			sh_q <= 16'h0000;
			cnt_q <= 5'h00;
		end else begin
			sh_q <= sh_d;
			cnt_q <= cnt_d;
		end
	end
	always_ff @(posedge serial_clock_in or negedge rst_b) begin
		if (!rst_b) begin
			tog_q <= 1'b0;
			cap_q <= 16'h0000;
		end else begin
			tog_q <= tog_d;
			cap_q <= cap_d;
		end
	end
	// status byte sent back during the data phase, shifted on falling edges
	always_comb begin
		tx_d = tx_q;
		oe_d = 1'b1;
		if (cnt_q == 5'h08)
			tx_d = stat_l;
		else
			tx_d = {tx_q[6:0], 1'b0};
	end
	always_ff @(negedge serial_clock_in or posedge port_select_n) begin
		if (port_select_n) begin // RULE_11
			tx_q <= 8'h00;
			oe_q <= 1'b0;
		end else begin
			tx_q <= tx_d; // RULE_08
			oe_q <= oe_d;
		end
	end
	// ==========================================================
	// system domain: synchronisers
	logic [1:0] rst_s_q, sel_s_q, ld_s_q, tg_s_q, oe_s_q, dat_s_q;
	logic tg_old_q;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s_q <= 2'b00;
			sel_s_q <= 2'b11;
			ld_s_q <= 2'b00;
			tg_s_q <= 2'b00;
			oe_s_q <= 2'b00;
			dat_s_q <= 2'b00;
			tg_old_q <= 1'b0;
		end else begin
			rst_s_q <= {rst_s_q[0], hard_reset_low};
			sel_s_q <= {sel_s_q[0], port_select_n};
			ld_s_q <= {ld_s_q[0], eeprom_load_sel};
			tg_s_q <= {tg_s_q[0], tog_q};
			oe_s_q <= {oe_s_q[0], oe_q & ~port_select_n};
			dat_s_q <= {dat_s_q[0], tx_q[7]};
			tg_old_q <= tg_s_q[1];
		end
	end
	// ==========================================================
	// boot sequencer
	hcsp_state_t st_q, st_d;
	logic [31:0] bt_q, bt_d;
	always_comb begin
		st_d = st_q;
		bt_d = bt_q;
		case (st_q)
			HCSP_RESET: begin
				bt_d = 32'h0;
				if (rst_s_q[1])
					st_d = HCSP_BOOT;
			end
			HCSP_BOOT: begin
				bt_d = bt_q + 32'h1;
				if (bt_q == 32'(BOOT_CYCLES - 1))
					st_d = HCSP_RUN; // RULE_04
			end
			HCSP_RUN: st_d = HCSP_RUN;
			default: st_d = HCSP_RESET;
		endcase
		if (!rst_s_q[1])
			st_d = HCSP_RESET; // RULE_01
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= HCSP_RESET;
			bt_q <= 32'h0;
		end else begin
			st_q <= st_d;
			bt_q <= bt_d;
		end
	end
	// ==========================================================
	// word handling: two-entry buffer and reference select
	hcsp_word_t buf_q [2], buf_d [2];
	logic [1:0] n_q, n_d;
	logic [2:0] ref_d;
	logic cr_d, bo_d, li_d, wv_d, so_d, soe_d;
	hcsp_word_t w_d, in_w;
	logic push, pop;
	assign stat_l = {5'h00, ld_s_q[1], st_q == HCSP_RUN, st_q == HCSP_BOOT};
	always_comb begin
		in_w.cmd = cap_q[15:8];
		in_w.data = cap_q[7:0];
		in_w.eeprom = ld_s_q[1]; // RULE_05
		push = (tg_s_q[1] != tg_old_q) && (n_q != 2'h2) && (st_q != HCSP_RESET);
		pop = word_valid_q && word_ready;
		buf_d = buf_q;
		n_d = n_q;
		ref_d = ref_sel_q;
		if (pop) begin
			buf_d[0] = buf_q[1];
			n_d = n_q - 2'h1;
		end
		if (push) begin
			buf_d[n_d[0]] = in_w;
			n_d = n_d + 2'h1;
			if (!ld_s_q[1] && in_w.cmd == `HCSP_CMD_WR_REF && in_w.data[7:3] == 5'h00
				&& in_w.data[2:0] <= 3'h6)
				ref_d = in_w.data[2:0]; // RULE_16
		end
		wv_d = n_d != 2'h0;
		w_d = buf_d[0];
		cr_d = st_d == HCSP_RESET;
		bo_d = st_d == HCSP_RUN;
		li_d = st_d == HCSP_RUN && !ld_s_q[1];
		so_d = dat_s_q[1];
		soe_d = oe_s_q[1] & ~sel_s_q[1];
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			buf_q[0] <= '0;
			buf_q[1] <= '0;
			n_q <= 2'h0;
			ref_sel_q <= `HCSP_REF_SEL_RST;
			core_reset_q <= 1'b1;
			booted_q <= 1'b0;
			linearize_q <= 1'b0;
			word_valid_q <= 1'b0;
			word_q <= '0;
			serial_out <= 1'b0;
			serial_out_oe <= 1'b0;
		end else begin
			buf_q <= buf_d;
			n_q <= n_d;
			ref_sel_q <= ref_d;
			core_reset_q <= cr_d;
			booted_q <= bo_d;
			linearize_q <= li_d;
			word_valid_q <= wv_d;
			word_q <= w_d;
			serial_out <= so_d;
			serial_out_oe <= soe_d; // RULE_11
		end
	end
	// ==========================================================
	// checks
	run_needs_rel_a: assert property (@(posedge clk) disable iff (!rst_b)
		linearize_q |-> rst_s_q[1] || $past(rst_s_q[1])) else $error("run without release"); // RULE_01
	rst_holds_a: assert property (@(posedge clk) disable iff (!rst_b)
		!rst_s_q[1] |=> core_reset_q) else $error("reset not held"); // RULE_01
	boot_done_a: assert property (@(posedge clk) disable iff (!rst_b)
		(st_q == HCSP_BOOT && bt_q == 32'(BOOT_CYCLES - 1) && rst_s_q[1]) |=> booted_q)
		else $error("boot did not finish"); // RULE_04
	load_blocks_a: assert property (@(posedge clk) disable iff (!rst_b)
		ld_s_q[1] |=> !linearize_q) else $error("linearizing during load"); // RULE_05
	oe_desel_a: assert property (@(posedge clk) disable iff (!rst_b)
		sel_s_q[1] |=> !serial_out_oe) else $error("output driven while deselected"); // RULE_11
	buf_cap_a: assert property (@(posedge clk) disable iff (!rst_b)
		n_q <= 2'h2) else $error("buffer overrun"); // RULE_12
	ref_range_a: assert property (@(posedge clk) disable iff (!rst_b)
		ref_sel_q <= 3'h6) else $error("bad reference code"); // RULE_16
	word_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
		word_valid_q && !word_ready |=> word_valid_q && $stable(word_q))
		else $error("word dropped under stall"); // RULE_12
	// release of hard reset starts a fresh boot count
	sequence hcsp_release_s;
		$rose(rst_s_q[1]);
	endsequence
	sequence hcsp_boot_start_s;
		st_q == HCSP_BOOT && bt_q == 32'h0;
	endsequence
	boot_start_a: assert property (@(posedge clk) disable iff (!rst_b)
		hcsp_release_s |=> hcsp_boot_start_s) else $error("boot did not start"); // RULE_01
	reset_quiet_a: assert property (@(posedge clk) disable iff (!rst_b)
		core_reset_q |-> !booted_q && !linearize_q)
		else $error("running while in reset"); // RULE_01
	load_keeps_ref_a: assert property (@(posedge clk) disable iff (!rst_b)
		ld_s_q[1] |=> ref_sel_q == $past(ref_sel_q))
		else $error("reference changed during load"); // RULE_05
	word_shows_a: assert property (@(posedge clk) disable iff (!rst_b)
		n_q == 2'h0 && push |=> word_valid_q && word_q == $past(in_w))
		else $error("received word not shown"); // RULE_12
endmodule : hcsp_top

// File: rtl/hcsp_defines.svh
// constants for the host control serial port
`ifndef HCSP_DEFINES_SVH
`define HCSP_DEFINES_SVH
// ==========================================================
// boot timing
`define HCSP_BOOT_TIME_MS 3000
`define HCSP_CLK_MHZ 100
`define HCSP_BOOT_CYCLES (`HCSP_BOOT_TIME_MS * 1000 * `HCSP_CLK_MHZ)
// ==========================================================
// frame layout
`define HCSP_CMD_BITS 8
`define HCSP_DATA_BITS 8
`define HCSP_REF_SEL_RST 3'h4
`define HCSP_CMD_WR_REF 8'h01
`define HCSP_CMD_RD_STAT 8'h02
`endif

// File: rtl/hcsp_pkg.sv
// types for the host control serial port
package hcsp_pkg;
	typedef enum {HCSP_RESET, HCSP_BOOT, HCSP_RUN} hcsp_state_t;
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] data;
		logic eeprom;
	} hcsp_word_t;
endpackage : hcsp_pkg

// File: tb/hcsp_host_model.sv
// serial bus master model standing at the far side of the port
`timescale 1ns/1ns
module hcsp_host_model (
	// serial link
	output logic sclk,
	output logic ssn,
	output logic mosi,
	input wire logic miso
);
	initial begin
		sclk = 1'b0;
		ssn = 1'b1;
		mosi = 1'b0;
	end
	// mode 0 frame of n bits msb first, clock still outside the frame
	task frame(input logic [15:0] b, input int n, output logic [7:0] rx);
		#23 ssn = 1'b0;
		for (int i = 0; i < n; i++) begin
			mosi = b[15 - i];
			#80 sclk = 1'b1;
			rx = {rx[6:0], miso};
			#80 sclk = 1'b0;
		end
		#80 ssn = 1'b1;
		mosi = 1'b0;
	endtask : frame
endmodule : hcsp_host_model

// File: tb/host_control_serial_port_bench.sv
// self-checking bench for the host control serial port
`timescale 1ns/1ns
module host_control_serial_port_bench;
	import hcsp_pkg::*;
	localparam int BOOT = 100;
	logic clk, rst_b, hard_reset_low, eeprom_load_sel, word_ready, bt;
	logic sclk, ssn, mosi, serial_out, serial_out_oe, miso;
	logic core_reset_q, booted_q, linearize_q, word_valid_q;
	logic [2:0] ref_sel_q, ref_e;
	logic [7:0] rx, c;
	logic [31:0] seed;
	hcsp_word_t word_q;
	hcsp_word_t exp_q[$];
	int fails = 0;
	int compares = 0;
	// external pull-up on the shared data out line
	assign miso = serial_out_oe ? serial_out : 1'b1;
	hcsp_top #(.BOOT_CYCLES(BOOT)) hcsp_top_inst (.clk(clk), .rst_b(rst_b),
		.hard_reset_low(hard_reset_low), .eeprom_load_sel(eeprom_load_sel),
		.serial_clock_in(sclk), .port_select_n(ssn), .serial_in(mosi),
		.serial_out(serial_out), .serial_out_oe(serial_out_oe),
		.core_reset_q(core_reset_q), .booted_q(booted_q), .linearize_q(linearize_q),
		.ref_sel_q(ref_sel_q), .word_valid_q(word_valid_q), .word_q(word_q),
		.word_ready(word_ready));
	hcsp_host_model hcsp_host_model_inst (.sclk(sclk), .ssn(ssn), .mosi(mosi), .miso(miso));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task chk(input logic [18:0] s, input logic [18:0] e, input string m);
		compares++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask : chk
	task finish_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : finish_test
	// full frame, with the reference model kept beside it
	task send(input logic [7:0] cm, input logic [7:0] d);
		hcsp_host_model_inst.frame({cm, d}, 16, rx);
		chk(rx, {5'h0, eeprom_load_sel, bt, 1'b0}, "status");
		if (exp_q.size() < 2)
			exp_q.push_back({cm, d, eeprom_load_sel});
		if (cm == 8'h01 && d < 8'h07 && !eeprom_load_sel)
			ref_e = d[2:0];
		repeat (4) @(negedge clk);
		chk(serial_out_oe, 1'b0, "idle drive");
	endtask : send
	task drain();
		repeat (rnd() % 4) @(negedge clk);
		for (int i = 0; i < 40 && word_valid_q !== 1'b1; i++) @(negedge clk);
		chk(word_q, exp_q.pop_front(), "word");
		word_ready = 1'b1;
		@(negedge clk);
		word_ready = 1'b0;
		repeat (3) @(negedge clk);
		chk(ref_sel_q, ref_e, "ref code");
	endtask : drain
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#500000;
		fails++;
		finish_test();
	end
	initial begin
		{rst_b, hard_reset_low, eeprom_load_sel, word_ready, bt} = 5'h0;
		seed = 32'h43;
		ref_e = 3'h4;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		hcsp_host_model_inst.frame(16'h0102, 16, rx);
		repeat (10) @(negedge clk);
		chk(core_reset_q, 1'b1, "reset held");
		chk(word_valid_q, 1'b0, "frame in reset");
		hard_reset_low = 1'b1;
		repeat (BOOT / 2) @(negedge clk);
		chk(booted_q, 1'b0, "early boot");
		repeat (BOOT) @(negedge clk);
		bt = 1'b1;
		chk(linearize_q, 1'b1, "linearize");
		$display("boot test done");
		for (int d = 0; d < 8; d++) begin
			send(8'h01, d[7:0]);
			drain();
		end
		$display("code test done");
		for (int i = 0; i < 3; i++) send(rnd() | 8'h80, rnd());
		drain();
		drain();
		chk(word_valid_q, 1'b0, "buffer empty");
		$display("buffer test done");
		c = rnd();
		hcsp_host_model_inst.frame({c, 8'h00}, 8, rx);
		send(8'h01, 8'h05);
		drain();
		chk(exp_q.size(), 0, "abort");
		$display("abort test done");
		eeprom_load_sel = 1'b1;
		repeat (6) @(negedge clk);
		chk(linearize_q, 1'b0, "load mode");
		send(8'h01, 8'h03);
		drain();
		eeprom_load_sel = 1'b0;
		hard_reset_low = 1'b0;
		repeat (6) @(negedge clk);
		chk(core_reset_q, 1'b1, "second reset");
		$display("load test done");
		finish_test();
	end
endmodule : host_control_serial_port_bench
